/* include/sbkl_pkg.sv */
// shared constants for the serial boot kernel loader
package sbkl_pkg;
    localparam int          WORD_W        = 32;
    localparam int          KERNEL_WORDS  = 384;
    localparam int          CNT_W         = 9;
    localparam logic [7:0]  READ_CMD_MSB  = 8'h03;
    localparam logic [23:0] READ_ADDR     = 24'h000000;
    localparam logic [1:0]  CFG_SLAVE     = 2'h0;
    localparam logic [1:0]  CFG_MASTER    = 2'h1;
    localparam int          CMD_BITS      = 32;
    localparam int          CLK_HZ        = 10000000;
    localparam int          SCK_HZ        = 1250000;
    localparam int          SCK_HALF      = CLK_HZ / (2 * SCK_HZ);
    localparam logic [7:0]  SCK_HALF_CNT  = 8'(SCK_HALF < 1 ? 1 : SCK_HALF);
    // slave boot port defaults
    localparam logic        DEF_PORT_EN   = 1'b1;
    localparam logic        DEF_ROLE      = 1'b0;
    localparam logic        DEF_MSB_FIRST = 1'b0;
    localparam logic [1:0]  DEF_WORD_LEN  = 2'h2;
    localparam logic        DEF_OUT_DIS   = 1'b1;
    localparam logic        DEF_SEND_ZERO = 1'b0;
    localparam logic        DEF_RX_DMA    = 1'b1;
    localparam logic        DEF_CLK_POL   = 1'b1;
    localparam logic        DEF_CLK_PHASE = 1'b1;
    localparam logic [5:0]  CTL_W         = 6'h0b;
endpackage

/* logic/sbkl_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sbkl_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            meta_ff <= '0;
            q       <= '0;
        end
        else
        begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

/* logic/sbkl_loader.sv */
// serial boot kernel loader: slave and master boot into internal memory
`timescale 1ns/1ps
// How it works
// - receive shifter always builds 32-bit words
// - units packed lsb first, low unit first
// - slave transfer starts only on select fall
// - kernel dma count 384 words, 32 bits
// - slave boot port defaults preset
// - slave clock active low, phase set
// - master drives clock and chip select low
// - master sends read 0x03, zero address
// - command byte shifted out msb first
// - command-time word discarded, never stored
// - first data bit at clock cycle 32
// - clock and select held until kernel_done
// - boot dma set up after reset automatically
// - boot pins sampled: 00 slave, 01 master
module sbkl_loader
    import sbkl_pkg::*;
#(
    parameter int KWORDS = KERNEL_WORDS
) (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic [1:0]                boot_cfg,
    input  wire logic                      slave_select_in,
    input  wire logic                      serial_shift_clock_in,
    input  wire logic                      data_in,
    output logic                           serial_shift_clock_out,
    output logic                           serial_shift_clock_oe,
    output logic                           boot_chip_select_out,
    output logic                           data_out,
    output logic                           data_out_oe,
    output logic                           mem_we,
    output logic [sbkl_pkg::CNT_W-1:0]     mem_addr,
    output logic [sbkl_pkg::WORD_W-1:0]    mem_wdata,
    output logic [sbkl_pkg::CTL_W-1:0]     serial_port_control,
    output logic                           core_release,
    input  wire logic                      kernel_done
);
    import sbkl_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        S_CFG    = 5'b00001,
        S_SLAVE  = 5'b00010,
        S_MASTER = 5'b00100,
        S_KERNEL = 5'b01000,
        S_IDLE   = 5'b10000
    } sbkl_state_t;

    typedef struct packed {
        sbkl_state_t             st;
        logic                    master;
        logic [WORD_W-1:0]       rx_sh;
        logic [WORD_W-1:0]       tx_sh;
        logic [5:0]              bit_cnt;
        logic                    cmd_phase;
        logic [CNT_W-1:0]        dma_cnt;
        logic [CNT_W-1:0]        addr;
        logic                    sel_armed;
        logic                    active;
        logic                    sck_prev;
        logic                    sel_prev;
        logic [7:0]              div;
        logic                    sck_o;
        logic                    cs_o;
        logic                    we;
        logic [WORD_W-1:0]       wdata;
        logic                    rel;
        logic                    sck_oe;
        logic                    dout_oe;
        logic [CTL_W-1:0]        ctl;
    } sbkl_regs_t;

    sbkl_regs_t r_ff;
    sbkl_regs_t nxt_r;
    logic [2:0] pins_s;

    sbkl_sync #(.W(3)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    ({slave_select_in, serial_shift_clock_in, data_in}),
        .q    (pins_s)
    );

    wire logic sel_s = pins_s[2];
    wire logic sck_s = pins_s[1];
    wire logic din_s = pins_s[0];

    // read opcode bit-reversed into the low byte so it leaves msb first
    function automatic logic [WORD_W-1:0] cmd_word();
        logic [WORD_W-1:0] w;
        w = '0;
        for (int i = 0; i < 8; i++)
            w[i] = READ_CMD_MSB[7-i];
        w[WORD_W-1:8] = READ_ADDR;
        return w;
    endfunction

    // port control view: role and output-line enable follow the boot type
    function automatic logic [CTL_W-1:0] ctl_view(input logic m);
        return {DEF_PORT_EN, m, DEF_MSB_FIRST, DEF_WORD_LEN, DEF_OUT_DIS & ~m,
                DEF_SEND_ZERO, DEF_RX_DMA, DEF_CLK_POL, DEF_CLK_PHASE, 1'b0};
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic sck_edge_cap;
        logic word_done;
        sck_edge_cap = 1'b0;
        word_done    = 1'b0;
        nxt_r        = r_ff;
        nxt_r.we     = 1'b0;
        nxt_r.sck_prev = sck_s;
        nxt_r.sel_prev = sel_s;
        case (r_ff.st)
            S_CFG:
            begin
                nxt_r.master  = (boot_cfg == CFG_MASTER);
                nxt_r.ctl     = ctl_view(boot_cfg == CFG_MASTER);
                nxt_r.dma_cnt = CNT_W'(KWORDS);
                nxt_r.addr    = '0;
                nxt_r.bit_cnt = '0;
                if (boot_cfg == CFG_MASTER)
                begin
                    nxt_r.st        = S_MASTER;
                    nxt_r.cs_o      = 1'b0;
                    nxt_r.sck_oe    = 1'b1;
                    nxt_r.dout_oe   = 1'b1;
                    nxt_r.tx_sh     = cmd_word();
                    nxt_r.cmd_phase = 1'b1;
                end
                else if (boot_cfg == CFG_SLAVE)
                    nxt_r.st = S_SLAVE;
                else
                    nxt_r.st = S_IDLE;
            end
            S_SLAVE:
            begin
                // a select tied low never arms the port
                if (r_ff.sel_prev && !sel_s)
                    nxt_r.active = 1'b1;
                else if (sel_s)
                    nxt_r.active = 1'b0;
                // active low clock, phase 1: sample on rising edge
                if (r_ff.active && !sel_s && !r_ff.sck_prev && sck_s)
                    sck_edge_cap = 1'b1;
            end
            S_MASTER:
            begin
                if (r_ff.div == 8'h00)
                begin
                    nxt_r.div   = SCK_HALF_CNT - 8'h01;
                    nxt_r.sck_o = ~r_ff.sck_o;
                    if (r_ff.sck_o)
                        nxt_r.tx_sh = {1'b0, r_ff.tx_sh[WORD_W-1:1]};
                    else
                        sck_edge_cap = 1'b1;
                end
                else
                    nxt_r.div = r_ff.div - 8'h01;
            end
            S_KERNEL:
            begin
                nxt_r.rel = 1'b1;
                if (kernel_done)
                begin
                    nxt_r.st   = S_IDLE;
                    nxt_r.cs_o = 1'b1;
                    nxt_r.sck_o = 1'b0;
                    nxt_r.sck_oe = 1'b0;
                end
                else if (r_ff.master)
                begin
                    if (r_ff.div == 8'h00)
                    begin
                        nxt_r.div   = SCK_HALF_CNT - 8'h01;
                        nxt_r.sck_o = ~r_ff.sck_o;
                    end
                    else
                        nxt_r.div = r_ff.div - 8'h01;
                end
            end
            S_IDLE:
                nxt_r.st = S_IDLE;
            default:
                nxt_r.st = S_CFG;
        endcase
        if (sck_edge_cap)
        begin
            // new bit enters the top: first bit ends at bit 0
            nxt_r.rx_sh   = {din_s, r_ff.rx_sh[WORD_W-1:1]};
            nxt_r.bit_cnt = r_ff.bit_cnt + 6'h01;
            word_done     = (r_ff.bit_cnt == 6'(WORD_W - 1));
        end
        if (word_done)
        begin
            nxt_r.bit_cnt = '0;
            if (r_ff.cmd_phase)
                nxt_r.cmd_phase = 1'b0;
            else
            begin
                nxt_r.we      = 1'b1;
                nxt_r.wdata   = nxt_r.rx_sh;
                nxt_r.addr    = r_ff.addr + CNT_W'(1);
                nxt_r.dma_cnt = r_ff.dma_cnt - CNT_W'(1);
                if (r_ff.dma_cnt == CNT_W'(1))
                begin
                    nxt_r.st      = S_KERNEL;
                    nxt_r.dout_oe = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            r_ff      <= '0;
            r_ff.st   <= S_CFG;
            r_ff.cs_o <= 1'b1;
            r_ff.ctl  <= ctl_view(1'b0);
        end
        else
            r_ff <= nxt_r;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign serial_shift_clock_out = r_ff.sck_o;
    assign serial_shift_clock_oe  = r_ff.sck_oe;
    assign boot_chip_select_out   = r_ff.cs_o;
    assign data_out               = r_ff.tx_sh[0];
    assign data_out_oe            = r_ff.dout_oe;
    assign mem_we                 = r_ff.we;
    assign mem_addr               = r_ff.addr;
    assign mem_wdata              = r_ff.wdata;
    assign core_release           = r_ff.rel;
    assign serial_port_control    = r_ff.ctl;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_word_written;
        r_ff.we ##1 !r_ff.we;
    endsequence

    a_store_needs_data: assert property (@(posedge clk) disable iff (!nrst)
        r_ff.we |-> !$past(r_ff.cmd_phase) || $past(r_ff.st) != S_MASTER)
        else $error("command word stored");
    a_write_single: assert property (@(posedge clk) disable iff (!nrst)
        $rose(r_ff.we) |-> s_word_written)
        else $error("write strobe too long");
    a_cs_held: assert property (@(posedge clk) disable iff (!nrst)
        (r_ff.st == S_KERNEL && r_ff.master && !kernel_done) |=> !r_ff.cs_o)
        else $error("chip select dropped early");
    a_addr_steps: assert property (@(posedge clk) disable iff (!nrst)
        r_ff.we |-> r_ff.addr == $past(r_ff.addr) + CNT_W'(1))
        else $error("address not stepped");
    a_release_last: assert property (@(posedge clk) disable iff (!nrst)
        $rose(r_ff.rel) |-> r_ff.dma_cnt == '0)
        else $error("release before count zero");
    a_cfg_select: assert property (@(posedge clk) disable iff (!nrst)
        (r_ff.st == S_CFG && boot_cfg == CFG_MASTER) |=> r_ff.st == S_MASTER && !r_ff.cs_o)
        else $error("master boot not entered");
    a_cmd_first: assert property (@(posedge clk) disable iff (!nrst)
        (r_ff.st == S_CFG && boot_cfg == CFG_MASTER) |=> r_ff.tx_sh == cmd_word())
        else $error("read command wrong");
    a_slave_arm: assert property (@(posedge clk) disable iff (!nrst)
        $rose(r_ff.active) |-> $past(r_ff.sel_prev) && !$past(sel_s))
        else $error("armed without select fall");
endmodule

/* test/sbkl_flash_model.sv */
// serial flash model answering the loader's master boot read
`timescale 1ns/1ps
module sbkl_flash_model #(
    parameter int START = 32
) (
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    output logic             miso,
    output logic [31:0]      cmd_seen
);
    // start 24 is a 16-bit address part: a pad byte fills up to bit 32
    localparam logic [7:0] PAD = 8'ha5;
    int unsigned nbits;
    logic [31:0] w;
    initial
    begin
        miso = 1'b0;
        nbits = 0;
        cmd_seen = 32'h0;
    end
    always @(negedge cs_n) nbits = 0;
    always @(posedge sck)
    begin
        if (cs_n == 1'b0)
        begin
            if (nbits < 32)
                cmd_seen = {cmd_seen[30:0], mosi};
            nbits++;
        end
    end
    // no pull on the line: released or silent means last value inverted
    always @(negedge sck or posedge cs_n)
    begin
        w = 32'h80000001 ^ (32'h01010101 * ((nbits - 32) / 32));
        if (cs_n == 1'b1 || nbits < START)
            miso <= ~miso;
        else if (nbits < 32)
            miso <= PAD[nbits % 8];
        else
            miso <= w[(nbits - 32) % 32];
    end
endmodule

/* test/tb_spi_boot_kernel_loader.sv */
// self-checking bench for the serial boot kernel loader
`timescale 1ns/1ps
module tb_spi_boot_kernel_loader;
    import sbkl_pkg::*;
    localparam int KW = 4;
    logic clk, nrst, tb_sck, tb_sel, tb_din, kernel_done, sck_w, d_w;
    logic [1:0] boot_cfg;
    logic sck_o, sck_oe, cs_n, mosi, mosi_oe, mem_we, core_release, miso, oe_seen;
    logic [CNT_W-1:0] mem_addr;
    logic [WORD_W-1:0] mem_wdata, w;
    logic [CTL_W-1:0] ctl;
    logic [31:0] cmd_seen;
    logic [WORD_W-1:0] got[$];
    int bad_count, n_checks;
    // the clock pin is shared: the design wins while it drives
    assign sck_w = sck_oe ? sck_o : tb_sck;
    assign d_w = (boot_cfg == CFG_MASTER) ? miso : tb_din;
    sbkl_loader #(.KWORDS(KW)) i_dut (.clk(clk), .nrst(nrst), .boot_cfg(boot_cfg),
        .slave_select_in(tb_sel), .serial_shift_clock_in(sck_w), .data_in(d_w),
        .serial_shift_clock_out(sck_o), .serial_shift_clock_oe(sck_oe),
        .boot_chip_select_out(cs_n), .data_out(mosi), .data_out_oe(mosi_oe),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .serial_port_control(ctl), .core_release(core_release),
        .kernel_done(kernel_done));
    sbkl_flash_model #(.START(24)) i_flash (.sck(sck_o), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .cmd_seen(cmd_seen));
    // ------
    // helpers
    // ------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] exp_word(input int k);
        return 32'h80000001 ^ (32'h01010101 * k[31:0]);
    endfunction
    task automatic do_reset(input logic [1:0] cfg);
        @(posedge clk);
        #10 nrst = 1'b0;
        boot_cfg = cfg;
        repeat (5) @(posedge clk);
        #10 nrst = 1'b1;
        got.delete();
        oe_seen = 1'b0;
    endtask
    task automatic shift_bit(input logic b);
        tb_sck = 1'b0;
        tb_din = b;
        #400 tb_sck = 1'b1;
        #400;
    endtask
    task automatic check_words();
        check(32'(got.size()), KW);
        foreach (got[k]) check(got[k], exp_word(k));
        check(32'(core_release), 32'h1);
    endtask
    // one-cycle strobe: looked at mid-cycle, where it stands settled
    always @(negedge clk)
    begin
        if (mem_we === 1'b1)
        begin
            got.push_back(mem_wdata);
            check(32'(mem_addr), 32'(got.size()));
        end
        if (mosi_oe === 1'b1)
            oe_seen <= 1'b1;
    end
    // ------
    // scenarios
    // ------
    task automatic slave_boot();
        do_reset(CFG_SLAVE);
        repeat (4) @(posedge clk);
        #10;
        // bits while select is still high must be ignored
        for (int i = 0; i < 40; i++) shift_bit(1'b1);
        check(32'(got.size()), 32'h0);
        check(32'(core_release), 32'h0);
        tb_sel = 1'b0;
        for (int i = 0; i < 32 * KW; i++)
        begin
            w = exp_word(i / 32);
            shift_bit(w[i % 32]);
        end
        tb_sel = 1'b1;
        tb_din = ~tb_din;
        repeat (20) @(posedge clk);
        #10;
        check_words();
        check(32'(ctl), 32'h4ae);
        check(32'(oe_seen), 32'h0);
    endtask
    task automatic master_boot();
        int n;
        int ch;
        logic t0;
        n = 0;
        ch = 0;
        do_reset(CFG_MASTER);
        while (got.size() < KW && n < 5000)
        begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        #10;
        check(cmd_seen, 32'h03000000);
        check_words();
        check({cs_n, sck_oe}, 32'h1);
        check({oe_seen, mosi_oe}, 32'h2);
        check(32'(ctl), 32'h68e);
        t0 = sck_o;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            #10;
            if (sck_o !== t0) ch++;
            t0 = sck_o;
        end
        check(32'(ch), 32'h2);
        kernel_done = 1'b1;
        repeat (10) @(posedge clk);
        #10 kernel_done = 1'b0;
        check({cs_n, sck_oe}, 32'h2);
    endtask
    task automatic idle_boot();
        do_reset(2'h3);
        repeat (300) @(posedge clk);
        check({cs_n, 31'(got.size())}, 32'h80000000);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #2000000;
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        {nrst, tb_sck, tb_sel, tb_din, kernel_done, oe_seen} = 6'h1c;
        boot_cfg = CFG_SLAVE;
        bad_count = 0;
        n_checks = 0;
        slave_boot();
        master_boot();
        idle_boot();
        report_and_stop();
    end
endmodule
